// file: rtl/temp_result_ecc_handshake_eol.sv
/*
 * Measurement control and result readout of the temperature sensor:
 * start commands, busy and acknowledge, handshake pin, battery-low flag.
 * Assumes a decoded command front end on the same clock, and pins
 * (handshake, mode, sub-address, battery compare) arriving asynchronously.
 */
`include "tsense_defines.svh"

module temp_result_ecc_handshake_eol #(
  parameter int CONV_CYCLES  = `CONV_CYCLES,
  parameter int PULSE_CYCLES = `START_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Decoded bus transaction from the serial front end
  input  wire logic        cmd_valid,
  input  wire logic [6:0]  cmd_addr,
  input  wire logic [1:0]  cmd_code,
  input  wire logic        cmd_rnw,
  input  wire logic [4:0]  cmd_data,
  output logic             cmd_ack,
  output logic [15:0]      rd_word,
  // Pins
  input  wire logic        mode_pin,
  input  wire logic        sub_addr_pin_hi,
  input  wire logic        sub_addr_pin_lo,
  input  wire logic        handshake_pin_in,
  output logic             handshake_pin_out,
  output logic             handshake_pin_oe_n,
  output logic             battery_low_out,
  // Analog side
  input  wire logic        supply_below,
  input  wire logic [11:0] adc_code,
  output logic [3:0]       battery_threshold,
  output logic             conv_active
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_DONE
  } conv_state_t;

  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int CW = $clog2(CONV_CYCLES + 1);

  conv_state_t  state_r;
  logic [CW-1:0] conv_cnt_r;
  logic [PW-1:0] low_cnt_r;
  logic [CW-1:0] run_len_r;
  logic [11:0]  code_r;
  logic         have_code_r;
  logic [4:0]   thresh_r;
  logic [1:0]   hs_sync_r;
  logic [1:0]   mode_sync_r;
  logic [1:0]   ahi_sync_r;
  logic [1:0]   alo_sync_r;
  logic [1:0]   bat_sync_r;
  logic         hs_start;
  logic         addr_hit;
  logic         soft_rst;
  logic         start_req;
  logic         twowire;
  tsense_res_if res ();

  // Two-stage synchronisers for every pin input
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_sync_r   <= 2'h3;
      mode_sync_r <= 2'h0;
      ahi_sync_r  <= 2'h0;
      alo_sync_r  <= 2'h0;
      bat_sync_r  <= 2'h0;
    end else begin
      hs_sync_r   <= {hs_sync_r[0], handshake_pin_in};
      mode_sync_r <= {mode_sync_r[0], mode_pin};
      ahi_sync_r  <= {ahi_sync_r[0], sub_addr_pin_hi};
      alo_sync_r  <= {alo_sync_r[0], sub_addr_pin_lo};
      bat_sync_r  <= {bat_sync_r[0], supply_below};
    end
  end

  assign twowire = mode_sync_r[1];

  // Address match: fixed base plus pin-selected sub-address
  assign addr_hit = cmd_valid &&
                    (cmd_addr == {`BASE_ADDR, ahi_sync_r[1], alo_sync_r[1]});
  assign soft_rst = addr_hit && !cmd_rnw &&
                    (cmd_code == 2'(tsense_pkg::CMD_RESET));

  // Count the host's low pulse; only a full-length pulse starts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r <= '0;
    end else if (hs_sync_r[1] || state_r != ST_IDLE) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != PW'(PULSE_CYCLES)) begin
      low_cnt_r <= low_cnt_r + PW'(1);
    end
  end

  // Start when the low pulse has lasted long enough and the host let go
  assign hs_start = (low_cnt_r == PW'(PULSE_CYCLES)) && hs_sync_r[1];

  // Command start or handshake start; battery result plays no part
  assign start_req = (addr_hit && !cmd_rnw &&
                      cmd_code == 2'(tsense_pkg::CMD_START)) || hs_start;

  // Conversion sequencer; a start while converting is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      conv_cnt_r <= '0;
    end else if (soft_rst) begin
      state_r    <= ST_IDLE;
      conv_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE, ST_DONE: begin
          if (start_req) begin
            state_r    <= ST_CONV;
            conv_cnt_r <= '0;
          end else if (state_r == ST_DONE && addr_hit && cmd_rnw &&
                       cmd_code == 2'(tsense_pkg::CMD_READ)) begin
            state_r <= ST_IDLE;
          end
        end
        ST_CONV: begin
          if (conv_cnt_r == CW'(CONV_CYCLES - 1)) begin
            state_r <= ST_DONE;
          end else begin
            conv_cnt_r <= conv_cnt_r + CW'(1);
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Latch the code at the end of a conversion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_r      <= 12'h000;
      have_code_r <= 1'b0;
    end else if (soft_rst) begin
      code_r      <= 12'h000;
      have_code_r <= 1'b0;
    end else if (state_r == ST_CONV && conv_cnt_r == CW'(CONV_CYCLES - 1)) begin
      code_r      <= adc_code;
      have_code_r <= 1'b1;
    end
  end

  // Threshold register: bit 4 enables, low four bits pick the level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      thresh_r <= `THRESH_RESET;
    end else if (soft_rst) begin
      thresh_r <= `THRESH_RESET;
    end else if (addr_hit && !cmd_rnw &&
                 cmd_code == 2'(tsense_pkg::CMD_THRESH)) begin
      thresh_r <= cmd_data;
    end
  end

  // Battery compare taken at each conversion start, frozen if disabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_low_out <= 1'b0;
    end else if (start_req && state_r != ST_CONV && thresh_r[4]) begin
      battery_low_out <= bat_sync_r[1];
    end
  end

  // Zero code unless a result exists and no conversion runs
  assign res.code    = (have_code_r && state_r != ST_CONV) ? code_r : 12'h000;
  assign res.twowire = twowire;

  result_encoder u_enc (
    .res (res.enc)
  );

  // Registered answer toward the bus front end; no ack while busy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ack <= 1'b0;
      rd_word <= 16'h0000;
    end else begin
      cmd_ack <= addr_hit && state_r != ST_CONV;
      rd_word <= res.word;
    end
  end

  // Handshake pin: driven low while done, released (pulled high) otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      handshake_pin_out  <= 1'b0;
      handshake_pin_oe_n <= 1'b1;
    end else begin
      handshake_pin_out  <= 1'b0;
      handshake_pin_oe_n <= !(state_r == ST_DONE);
    end
  end

  // Status outputs toward the analog side
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_threshold <= 4'(`THRESH_RESET);
      conv_active       <= 1'b0;
    end else begin
      battery_threshold <= thresh_r[3:0];
      conv_active       <= state_r == ST_CONV;
    end
  end

  // Helper count of cycles with conv_active high; it measures the visible
  // busy window, not the sequencer counter, so an off-by-one shows up
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_len_r <= '0;
    end else if (conv_active) begin
      run_len_r <= run_len_r + CW'(1);
    end else begin
      run_len_r <= '0;
    end
  end

  // Busy and acknowledge
  chk_busy_no_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == ST_CONV |=> !cmd_ack)
    else $error("ack while busy");

  chk_ack_on_hit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (addr_hit && state_r != ST_CONV) |=> cmd_ack)
    else $error("no ack for idle hit");

  chk_no_ack_miss: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !addr_hit |=> !cmd_ack)
    else $error("ack without address match");

  // Result word; masks pick the code bits that feed each check bit
  chk_zero_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == ST_CONV |=> rd_word[15:4] == 12'h000)
    else $error("code not zero");

  chk_code_lsb: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !twowire |=> rd_word[3:0] == 4'h0)
    else $error("check bits in four-wire mode");

  chk_ecc_d3: assert property (@(posedge ref_clk) disable iff (!rst_n)
    twowire |=> rd_word[3] == ^($past(res.code) & 12'hE3A))
    else $error("bad D3");

  chk_ecc_d2: assert property (@(posedge ref_clk) disable iff (!rst_n)
    twowire |=> rd_word[2] == ^($past(res.code) & 12'h9B6))
    else $error("bad D2");

  chk_ecc_d1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    twowire |=> rd_word[1] == ^($past(res.code) & 12'h4EE))
    else $error("bad D1");

  chk_ecc_d0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    twowire |=> rd_word[0] == ^($past(res.code) & 12'h35E))
    else $error("bad D0");

  // Conversion sequencing
  chk_ignore_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_CONV && conv_cnt_r != CW'(CONV_CYCLES - 1) && !soft_rst)
    |=> state_r == ST_CONV && conv_cnt_r == $past(conv_cnt_r) + CW'(1))
    else $error("start disturbed run");

  chk_start_taken: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (start_req && state_r != ST_CONV && !soft_rst) |=> state_r == ST_CONV && conv_cnt_r == '0)
    else $error("start not taken");

  chk_hs_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (hs_start && state_r == ST_IDLE && !soft_rst) |=> state_r == ST_CONV)
    else $error("handshake start lost");

  chk_code_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_CONV && conv_cnt_r == CW'(CONV_CYCLES - 1) && !soft_rst)
    |=> state_r == ST_DONE && code_r == $past(adc_code))
    else $error("code not latched at end");

  chk_conv_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (conv_active && state_r == ST_DONE) |-> run_len_r == CW'(CONV_CYCLES - 1))
    else $error("conversion length");

  chk_active_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == ST_CONV |=> conv_active)
    else $error("busy output low in conversion");

  // Handshake pin
  chk_done_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == ST_DONE |=> !handshake_pin_oe_n && !handshake_pin_out)
    else $error("handshake not low");

  chk_done_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_DONE && addr_hit && cmd_rnw && !start_req && !soft_rst &&
     cmd_code == 2'(tsense_pkg::CMD_READ)) |=> state_r == ST_IDLE)
    else $error("read did not end done");

  chk_pin_released: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r != ST_DONE |=> handshake_pin_oe_n)
    else $error("handshake driven outside done");

  chk_pin_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |-> !handshake_pin_out)
    else $error("handshake drive level not low");

  chk_pulse_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |-> low_cnt_r <= PW'(PULSE_CYCLES))
    else $error("pulse counter past limit");

  // Battery-low flag and threshold
  chk_eol_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (start_req && state_r != ST_CONV && thresh_r[4]) |=> battery_low_out == $past(bat_sync_r[1]))
    else $error("eol not sampled at start");

  chk_eol_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(start_req && state_r != ST_CONV && thresh_r[4]) |=> $stable(battery_low_out))
    else $error("eol moved between starts");

  chk_eol_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !thresh_r[4] |=> $stable(battery_low_out))
    else $error("eol changed");

  chk_thr_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (addr_hit && !cmd_rnw && cmd_code == 2'(tsense_pkg::CMD_THRESH)) |=> thresh_r == $past(cmd_data))
    else $error("threshold not written");

  chk_thr_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> battery_threshold == $past(thresh_r[3:0]))
    else $error("threshold output stale");

  chk_reset_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
    soft_rst |=> thresh_r == `THRESH_RESET && !have_code_r)
    else $error("reset command left state");
endmodule

// file: rtl/tsense_defines.svh
/*
 * Constants for the temperature result, handshake and battery-low logic.
 * Assumes a 200 MHz core clock; included by bare name.
 */
`ifndef TSENSE_DEFINES_SVH
`define TSENSE_DEFINES_SVH

// Core clock period in ps
`define CLK_PERIOD_PS      5000
// Conversion time in ms and cycles
`define CONV_TIME_MS       50
// Cycles per ms taken first, so no intermediate product leaves 32 bits
`define CONV_CYCLES        (`CONV_TIME_MS * (1000000000 / `CLK_PERIOD_PS))
// Least handshake start pulse in us, and cycles rounded up
`define START_PULSE_US     50
`define START_PULSE_CYCLES ((`START_PULSE_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Fixed upper address bits
`define BASE_ADDR          5'h12
// Threshold register reset value: enabled, level five
`define THRESH_RESET       5'h15
// Result field positions
`define CODE_LSB           4
`define CODE_W             12

`endif

// file: rtl/tsense_pkg.sv
/*
 * Types shared by the result readout logic.
 * Assumes tsense_defines.svh is included by the users.
 */
package tsense_pkg;
  typedef enum logic [1:0] {
    CMD_READ,
    CMD_START,
    CMD_THRESH,
    CMD_RESET
  } cmd_code_t;
endpackage

// file: rtl/tsense_res_if.sv
/*
 * Carrier between the core and the result encoder.
 * Assumes both ends run on the same clock.
 */
interface tsense_res_if;
  logic [11:0] code;
  logic        twowire;
  logic [15:0] word;
  modport core (output code, output twowire, input word);
  modport enc  (input code, input twowire, output word);
endinterface

// file: rtl/result_encoder.sv
/*
 * Builds the 16-bit result word: 12-bit code on top, check bits below.
 * Assumes the code is held stable by the core.
 */
`include "tsense_defines.svh"

module result_encoder (
  tsense_res_if.enc res
);
  logic [15:0] d;
  logic [3:0]  chk;

  // Check bits over D15..D5 only; D4 stays outside every equation
  always_comb begin
    d      = {res.code, 4'h0};
    chk[3] = d[15] ^ d[14] ^ d[13] ^ d[9] ^ d[8] ^ d[7] ^ d[5];
    chk[2] = d[15] ^ d[12] ^ d[11] ^ d[9] ^ d[8] ^ d[6] ^ d[5];
    chk[1] = d[14] ^ d[11] ^ d[10] ^ d[9] ^ d[7] ^ d[6] ^ d[5];
    chk[0] = d[13] ^ d[12] ^ d[10] ^ d[8] ^ d[7] ^ d[6] ^ d[5];
  end

  // Low nibble carries check bits only in two-wire mode
  assign res.word = res.twowire ? {d[15:4], chk} : d;
endmodule

// file: bench/hs_host.sv
/*
 * Host side of the handshake pin: open-drain low driver plus pull-up.
 * Assumes the device pulls low only while its enable is low.
 */
module hs_host (
  // Clock
  input  wire logic ref_clk,
  // Device side of the pin
  input  wire logic dev_out,
  input  wire logic dev_oe_n,
  // Resolved pin level
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_low = 1'b0;
  // Wired-AND; the pull-up gives a defined high when nobody drives
  assign pin = !((!dev_oe_n && !dev_out) || host_low);
  // Hold low, then let go so the done level can be seen
  task automatic start_pulse(input int n);
    host_low <= 1'b1;
    repeat (n) @(posedge ref_clk);
    host_low <= 1'b0;
  endtask
endmodule

// file: bench/temp_result_ecc_handshake_eol_bench.sv
/*
 * Self-checking bench for the result, handshake and battery-low logic.
 * Assumes short counts: 50-cycle conversion and 8-cycle start pulse.
 */
module temp_result_ecc_handshake_eol_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 50;
  localparam int PULSE = 8;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [6:0]  cmd_addr = 7'h00;
  logic [1:0]  cmd_code = 2'h0;
  logic        cmd_rnw = 1'b0;
  logic [4:0]  cmd_data = 5'h00;
  logic        mode_pin = 1'b1;
  logic        sub_hi = 1'b1;
  logic        sub_lo = 1'b0;
  logic        supply_below = 1'b0;
  logic [11:0] adc_code = 12'h000;
  logic        cmd_ack, hs_pin, hs_out, hs_oe_n, eol, conv_active, ack;
  logic [15:0] rd_word;
  logic [3:0]  thr;
  int          num_errors = 0;
  int          comparisons = 0;
  int          seed = 38764;
  int          cycles = 0;
  int          t0;

  temp_result_ecc_handshake_eol #(.CONV_CYCLES(CONV), .PULSE_CYCLES(PULSE)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
    .cmd_code(cmd_code), .cmd_rnw(cmd_rnw), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .rd_word(rd_word), .mode_pin(mode_pin), .sub_addr_pin_hi(sub_hi),
    .sub_addr_pin_lo(sub_lo), .handshake_pin_in(hs_pin), .handshake_pin_out(hs_out),
    .handshake_pin_oe_n(hs_oe_n), .battery_low_out(eol), .supply_below(supply_below),
    .adc_code(adc_code), .battery_threshold(thr), .conv_active(conv_active));
  hs_host host (.ref_clk(ref_clk), .dev_out(hs_out), .dev_oe_n(hs_oe_n), .pin(hs_pin));

  // Clock and a cycle ceiling, so a hang still ends in the verdict
  always #2.5 ref_clk = !ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end

  // Expected word: code on top, check bits only in two-wire mode; D4 left out
  function automatic logic [15:0] word_of(input logic [11:0] c, input logic tw);
    logic [15:0] d;
    d = {c, 4'h0};
    if (tw) begin
      d[3] = ^{d[15], d[14], d[13], d[9], d[8], d[7], d[5]};
      d[2] = ^{d[15], d[12], d[11], d[9], d[8], d[6], d[5]};
      d[1] = ^{d[14], d[11], d[10], d[9], d[7], d[6], d[5]};
      d[0] = ^{d[13], d[12], d[10], d[8], d[7], d[6], d[5]};
    end
    return d;
  endfunction

  // Host decoder: syndrome from recomputed check bits; D4 never shows
  function automatic logic [3:0] syn(input logic [15:0] w);
    logic [15:0] r;
    r = word_of(w[15:4], 1'b1);
    return r[3:0] ^ w[3:0];
  endfunction

  // Flip the one bit whose syndrome column matches
  function automatic logic [15:0] fix(input logic [15:0] w);
    logic [15:0] f;
    f = w;
    for (int b = 0; b < 16; b++) begin
      if (syn(w) != 4'h0 && syn(16'h0001 << b) == syn(w)) f[b] = !f[b];
    end
    return f;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One decoded transaction; a miss flips a sub-address bit
  task automatic send(input logic [1:0] code, input logic rnw, input logic [4:0] data,
                      input logic hit);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_rnw <= rnw;
    cmd_data <= data;
    cmd_addr <= {5'h12, sub_hi ^ !hit, sub_lo};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    ack = cmd_ack;
  endtask

  // Waits for done; length counted from the accepted start
  task automatic finish(input logic tw);
    int pos;
    for (int n = 0; n < 200 && hs_oe_n !== 1'b0; n++) @(posedge ref_clk);
    #1;
    check("conv_len", 16'(cycles - t0 inside {[CONV:CONV + 4]}), 16'h1);
    check("hs_low", 16'(hs_pin), 16'h0);
    send(2'h0, 1'b1, 5'h00, 1'b1);
    check("rd_ack", 16'(ack), 16'h1);
    check("rd_word", rd_word, word_of(adc_code, tw));
    if (tw) begin
      pos = $random(seed) & 15;
      if (pos == 4) pos = 5;
      check("ecc_fix", fix(rd_word ^ (16'h0001 << pos)), word_of(adc_code, 1'b1));
      check("ecc_two", 16'(syn(rd_word ^ 16'h0300) != 4'h0), 16'h1);
    end
    repeat (3) @(posedge ref_clk);
    check("hs_free", 16'(hs_pin), 16'h1);
  endtask

  task automatic start(input logic below);
    @(posedge ref_clk);
    adc_code <= 12'($random(seed));
    supply_below <= below;
    repeat (3) @(posedge ref_clk);
    send(2'h1, 1'b0, 5'h00, 1'b1);
    t0 = cycles;
    check("st_ack", 16'(ack), 16'h1);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check("rst_word", rd_word, 16'h0000);
    check("rst_thr", 16'(thr), 16'h5);
    check("rst_eol", 16'(eol), 16'h0);
    check("rst_pin", 16'(hs_pin), 16'h1);
    send(2'h0, 1'b1, 5'h00, 1'b0);
    check("miss_ack", 16'(ack), 16'h0);
    $display("test reset and address done");
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      mode_pin <= i[0];
      start(i[1]);
      repeat (2) @(posedge ref_clk);
      #1;
      check("eol", 16'(eol), 16'(i[1]));
      repeat (20) @(posedge ref_clk);
      send(2'h1, 1'b0, 5'h00, 1'b1);
      check("busy_ack", 16'(ack), 16'h0);
      check("busy_word", rd_word, 16'h0000);
      finish(i[0]);
    end
    $display("test conversions done");
    for (int k = 0; k < 16; k++) begin
      send(2'h2, 1'b0, {1'b1, 4'(k)}, 1'b1);
      @(posedge ref_clk);
      #1;
      check("thr", 16'(thr), 16'(k));
    end
    start(1'b1);
    finish(1'b1);
    send(2'h2, 1'b0, 5'h0A, 1'b1);
    @(posedge ref_clk);
    supply_below <= 1'b0;
    repeat (4) @(posedge ref_clk);
    host.start_pulse(PULSE + 4);
    for (int n = 0; n < 10 && conv_active !== 1'b1; n++) @(posedge ref_clk);
    #1;
    t0 = cycles - 3;
    check("hs_start", 16'(conv_active), 16'h1);
    check("eol_hold", 16'(eol), 16'h1);
    finish(1'b1);
    $display("test threshold and handshake done");
    send(2'h3, 1'b0, 5'h00, 1'b1);
    repeat (2) @(posedge ref_clk);
    #1;
    check("rst_cmd_word", rd_word, 16'h0000);
    check("rst_cmd_thr", 16'(thr), 16'h5);
    $display("test chip reset done");
    close_out();
  end
endmodule
